// *** rtl/flash_self_program_sequencer.sv ***
/*
  flash self-program sequencer: apb register file, store window,
  temporary page buffer, erase/write timing, section blocking.
  assumes the cpu reaches it over apb on pclk and that eeprom_write
  is a same-clock pulse from the eeprom controller.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_sequencer
  import spm_pkg::*;
#(
  parameter int WORD_W     = 5,    // word-in-page field width
  parameter int PAGE_W     = 7,    // page field width
  parameter int NONUPDATABLE_SECTION_PAGE  = 96,   // first nonupdatable page
  parameter int OP_CYCLES  = 4000  // erase or write duration
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              eeprom_write,
  input  wire logic [WORD_W-1:0] flash_rd_idx,
  output logic      [15:0]       flash_rd_data,
  output logic                   flash_erase,
  output logic                   flash_program,
  output logic      [PAGE_W-1:0] flash_page,
  output logic                   cpu_stall,
  output logic                   updatable_read_block,
  output logic                   ready_irq,
  output logic      [LOCK_W-1:0] lock_bits
);
  localparam int WORDS = 1 << WORD_W;          // buffer depth
  localparam int CNT_W = $clog2(OP_CYCLES + 1); // op counter width

  logic [4:0]        cmd_q;      // armed low control bits
  logic [2:0]        arm_q;      // store window countdown
  logic              ie_q;       // interrupt enable
  logic              busy_q;     // updatable section busy
  logic [15:0]       ptr_q;      // address pointer
  logic [15:0]       data_q;     // data register pair
  logic [LOCK_W-1:0] lock_q;     // boot lock bits
  logic [CNT_W-1:0]  op_cnt_q;   // remaining op cycles
  logic              nonupdatable_section_q;     // op targets nonupdatable page
  logic              op_wr_q;    // running op is a page write
  logic [WORDS-1:0]  vld_q;      // loaded-location flags
  logic [15:0]       buf_q [WORDS]; // temporary page buffer
  logic [31:0]       rdata_d;    // read mux

  // decoded bus strobes
  logic acc_wr;
  logic ctrl_wr;
  logic cmd_ok;
  logic op_active;
  logic op_done;
  logic store_go;
  logic buf_clr;
  logic [PAGE_W-1:0] page_sel;
  ctrl_t ctrl_view;
  ctrl_t ctrl_in;   // incoming control byte, by field

  assign acc_wr    = psel & penable & pwrite;
  assign ctrl_wr   = acc_wr & (paddr == ADDR_CTRL);
  assign op_active = (op_cnt_q != '0);
  assign op_done   = (op_cnt_q == CNT_W'(1));
  // only five patterns do anything, and never while programming
  assign cmd_ok    = !op_active & ((pwdata[4:0] == CMD_LOAD) |
                     (pwdata[4:0] == CMD_ERASE) | (pwdata[4:0] == CMD_WRITE) |
                     (pwdata[4:0] == CMD_LOCK) | (pwdata[4:0] == CMD_RSRE));
  // store counts only inside the armed window
  assign store_go  = acc_wr & (paddr == ADDR_STORE) & (arm_q != '0) &
                     cmd_q[0] & !op_active;
  assign page_sel  = ptr_q[WORD_W+1 +: PAGE_W];
  assign ctrl_in   = ctrl_t'(pwdata[7:0]);

  // apb answers at once; unmapped offsets flag an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (paddr != ADDR_CTRL) &
                   (paddr != ADDR_PTR) & (paddr != ADDR_DATA) &
                   (paddr != ADDR_LOCK) & (paddr != ADDR_STORE);

  // level outputs derived from state
  assign ready_irq            = ie_q & !cmd_q[0];
  assign cpu_stall            = op_active & nonupdatable_section_q;
  // only the updatable side is blocked; boot code keeps running unless the op targets a nonupdatable page
  assign updatable_read_block = busy_q | op_active;
  assign lock_bits            = lock_q;

  // armed command and store window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_q <= CMD_NONE;
      arm_q <= '0;
    end
    else if (ctrl_wr && cmd_ok)
    begin
      cmd_q <= pwdata[4:0];
      arm_q <= ARM_CYCLES;
    end
    else if (store_go)
    begin
      arm_q <= '0;
      // erase and write keep store enable up until done
      if (cmd_q != CMD_ERASE && cmd_q != CMD_WRITE)
        cmd_q <= CMD_NONE;
    end
    else if (op_done)
      cmd_q <= CMD_NONE;
    else if (arm_q != '0 && !op_active)
    begin
      // window lapses without a store
      arm_q <= arm_q - 3'h1;
      if (arm_q == 3'h1)
        cmd_q <= CMD_NONE;
    end
  end

  // interrupt enable, writable at any time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ie_q <= 1'b0;
    else if (ctrl_wr)
      ie_q <= ctrl_in.ie;
  end

  // pointer and data pair, plain storage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ptr_q  <= '0;
      data_q <= '0;
    end
    else if (acc_wr && paddr == ADDR_PTR)
      ptr_q <= pwdata[15:0];
    else if (acc_wr && paddr == ADDR_DATA)
      data_q <= pwdata[15:0];
  end

  // erase and write timer; page latched so pointer is free again
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_cnt_q      <= '0;
      nonupdatable_section_q        <= 1'b0;
      op_wr_q       <= 1'b0;
      flash_erase   <= 1'b0;
      flash_program <= 1'b0;
      flash_page    <= '0;
    end
    else
    begin
      flash_erase   <= 1'b0;
      flash_program <= 1'b0;
      if (store_go && (cmd_q == CMD_ERASE || cmd_q == CMD_WRITE))
      begin
        // data pair ignored, only the page field is used
        op_cnt_q      <= CNT_W'(OP_CYCLES);
        nonupdatable_section_q        <= (int'(page_sel) >= NONUPDATABLE_SECTION_PAGE);
        op_wr_q       <= (cmd_q == CMD_WRITE);
        flash_erase   <= (cmd_q == CMD_ERASE);
        flash_program <= (cmd_q == CMD_WRITE);
        flash_page    <= page_sel;
      end
      else if (op_active)
        op_cnt_q <= op_cnt_q - CNT_W'(1);
    end
  end

  // busy flag: set by an updatable op, cleared by load, read enable or a nonupdatable op
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_q <= 1'b0;
    else if (store_go && (cmd_q == CMD_ERASE || cmd_q == CMD_WRITE))
      busy_q <= (int'(page_sel) < NONUPDATABLE_SECTION_PAGE);
    else if (store_go && (cmd_q == CMD_LOAD || cmd_q == CMD_RSRE))
      busy_q <= 1'b0;
  end

  // boot lock bits; programming can only clear bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lock_q <= LOCK_ERASED;
    else if (store_go && cmd_q == CMD_LOCK)
      lock_q <= lock_q & data_q[LOCK_LSB +: LOCK_W];
  end

  // whole-buffer clear sources
  assign buf_clr = (op_done & op_wr_q) |
                   (ctrl_wr & cmd_ok & ctrl_in.rsre) |
                   (eeprom_write & (|vld_q));

  // one storage slot per buffer word
  for (genvar i = 0; i < WORDS; i++)
  begin : g_buf
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        buf_q[i] <= '0;
        vld_q[i] <= 1'b0;
      end
      else if (buf_clr)
      begin
        buf_q[i] <= '0;
        vld_q[i] <= 1'b0;
      end
      else if (store_go && cmd_q == CMD_LOAD &&
               ptr_q[1 +: WORD_W] == WORD_W'(i))
      begin
        // second load of a slot is unsupported; last one wins
        buf_q[i] <= data_q;
        vld_q[i] <= 1'b1;
      end
    end
  end

  // buffer read port toward the flash array
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flash_rd_data <= '0;
    else
      flash_rd_data <= buf_q[flash_rd_idx];
  end

  // register read mux
  always_comb
  begin
    ctrl_view = '{ie: ie_q, busy: busy_q, rsvd: 1'b0, rsre: cmd_q[4],
                  lockset: cmd_q[3], pgwr: cmd_q[2], pger: cmd_q[1],
                  sen: cmd_q[0]};
    unique case (paddr)
      ADDR_CTRL: rdata_d = {24'h000000, ctrl_view};
      ADDR_PTR:  rdata_d = {16'h0000, ptr_q};
      ADDR_DATA: rdata_d = {16'h0000, data_q};
      ADDR_LOCK: rdata_d = {28'h0000000, lock_q};
      default:   rdata_d = 32'h00000000;
    endcase
  end

  // read data captured in setup, held through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= rdata_d;
  end

  // checks
  chk_arm_window: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_wr && cmd_ok) |=> (arm_q == ARM_CYCLES) ##4 (arm_q == '0))
    else $error("store window not four cycles");
  chk_sen_hold: assert property (@(posedge pclk) disable iff (!presetn)
    op_active |-> cmd_q[0])
    else $error("store enable dropped during op");
  chk_erase_start: assert property (@(posedge pclk) disable iff (!presetn)
    (store_go && cmd_q == CMD_ERASE) |=> flash_erase && op_active && cmd_q[0])
    else $error("erase did not start");
  chk_stall_nonupdatable_section: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_stall == (op_active && int'(flash_page) >= NONUPDATABLE_SECTION_PAGE))
    else $error("stall does not match latched page");
  chk_block_op: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(op_active) |-> updatable_read_block [*8])
    else $error("updatable section not blocked");
  chk_bad_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_wr && !cmd_ok && !op_done && arm_q != 3'h1) |=> $stable(cmd_q))
    else $error("undefined pattern changed state");
  chk_irq_ready: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(cmd_q[0]) && ie_q) |-> ready_irq)
    else $error("ready interrupt missing");
  chk_wr_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (op_done && op_wr_q) |=> (vld_q == '0) && !op_active)
    else $error("buffer not cleared after write");
  chk_load_busy: assert property (@(posedge pclk) disable iff (!presetn)
    (store_go && cmd_q == CMD_LOAD) |=> !busy_q && cmd_q == CMD_NONE)
    else $error("load left busy set");
  chk_ee_discard: assert property (@(posedge pclk) disable iff (!presetn)
    (eeprom_write && (|vld_q)) |=> (vld_q == '0))
    else $error("eeprom write kept buffer");
  cov_erase: cover property (@(posedge pclk) disable iff (!presetn)
    store_go && cmd_q == CMD_ERASE);
  cov_write_done: cover property (@(posedge pclk) disable iff (!presetn)
    op_done && op_wr_q);
  cov_lapse: cover property (@(posedge pclk) disable iff (!presetn)
    arm_q == 3'h1 && !store_go && !ctrl_wr);
endmodule : flash_self_program_sequencer
`default_nettype wire

// *** include/spm_pkg.sv ***
/*
  constants, register map and field layout of the flash self-program
  sequencer. assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package spm_pkg;
  // apb byte offsets, one aligned word each
  localparam logic [7:0] ADDR_CTRL  = 8'h00; // control and status
  localparam logic [7:0] ADDR_PTR   = 8'h04; // page address pointer
  localparam logic [7:0] ADDR_DATA  = 8'h08; // data register pair
  localparam logic [7:0] ADDR_LOCK  = 8'h0C; // boot lock bits, read only
  localparam logic [7:0] ADDR_STORE = 8'h10; // store instruction strobe
  // low five control bits: command patterns
  localparam logic [4:0] CMD_LOAD   = 5'h01;
  localparam logic [4:0] CMD_ERASE  = 5'h03;
  localparam logic [4:0] CMD_WRITE  = 5'h05;
  localparam logic [4:0] CMD_LOCK   = 5'h09;
  localparam logic [4:0] CMD_RSRE   = 5'h11;
  localparam logic [4:0] CMD_NONE   = 5'h00;
  // store window after arming, in clock cycles
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  // lock bit field inside the low data byte
  localparam int         LOCK_LSB   = 2;
  localparam int         LOCK_W     = 4;
  localparam logic [3:0] LOCK_ERASED = 4'hF; // unprogrammed lock bits
  // control register as software sees it
  typedef struct packed {
    logic ie;      // ready interrupt enable
    logic busy;    // updatable section busy
    logic rsvd;    // reads zero
    logic rsre;    // updatable section read enable
    logic lockset; // lock set command
    logic pgwr;    // page write command
    logic pger;    // page erase command
    logic sen;     // store enable
  } ctrl_t;
endpackage : spm_pkg
`default_nettype wire

// *** dv/cpu_core_model.sv ***
/*
  cpu core model: apb master issuing boot-loader register accesses.
  assumes pclk and presetn come from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // bus idle at time zero; no interrupts taken while programming
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  // one transfer; stays selected so a store may follow at once
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
  endtask : xfer
  // release the bus right after an edge, without waiting
  task automatic drop;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : drop
  // release for one cycle; boot section lock left to the bench
  task automatic idle;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : idle
endmodule : cpu_core_model
`default_nettype wire

// *** dv/tb_flash_self_program_sequencer.sv ***
/*
  self-checking bench of the self-program sequencer.
  assumes spm_pkg and the cpu core model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_flash_self_program_sequencer;
  import spm_pkg::*;
  localparam int OPS = 20;      // shortened op time
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic eeprom_write = 1'b0, flash_erase, flash_program, cpu_stall, ready_irq, blk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0]  flash_rd_idx = 5'h00;
  logic [15:0] flash_rd_data;
  logic [6:0]  flash_page;
  logic [3:0]  lock_bits;
  logic        e;
  int num_errors = 0, comparisons = 0, n_erase = 0;
  // 50 MHz clock
  always #10 pclk = ~pclk;
  // count erase pulses for refusal checks
  always @(posedge pclk) if (flash_erase === 1'b1) n_erase++;
  cpu_core_model cpu (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  flash_self_program_sequencer #(.OP_CYCLES(OPS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eeprom_write(eeprom_write), .flash_rd_idx(flash_rd_idx), .flash_rd_data(flash_rd_data),
    .flash_erase(flash_erase), .flash_program(flash_program), .flash_page(flash_page), .cpu_stall(cpu_stall),
    .updatable_read_block(blk), .ready_irq(ready_irq), .lock_bits(lock_bits));
  // compare and count
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // pointer from page and word index; word bits zero for erase and write
  function automatic logic [31:0] ptr(input int p, input int w);
    return (p << 6) | (w << 1);
  endfunction : ptr
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, q, e);
    cpu.idle();
  endtask : wr
  // ctrl write then store right behind it, inside the window
  task automatic cmd(input logic [7:0] c);
    cpu.xfer(1'b1, ADDR_CTRL, {24'h0, c}, q, e);
    cpu.xfer(1'b1, ADDR_STORE, 32'h0, q, e);
    cpu.idle();
  endtask : cmd
  // ctrl write and store, then stop mid-period of the launch cycle
  task automatic op_cmd(input logic [7:0] c);
    cpu.xfer(1'b1, ADDR_CTRL, {24'h0, c}, q, e);
    cpu.xfer(1'b1, ADDR_STORE, 32'h0, q, e);
    cpu.drop();
    @(negedge pclk);
  endtask : op_cmd
  task automatic ctrl_is(input logic [7:0] x);
    cpu.xfer(1'b0, ADDR_CTRL, 32'h0, q, e);
    cpu.idle();
    chk("ctrl", {24'h0, x}, q);
    chk("slverr", 1'b0, e);
  endtask : ctrl_is
  // buffer word seen one cycle after index
  task automatic buf_is(input logic [4:0] w, input logic [15:0] x);
    flash_rd_idx <= w;
    repeat (3) @(posedge pclk);
    chk("buffer", {16'h0, x}, {16'h0, flash_rd_data});
  endtask : buf_is
  // load one word; a second load of a slot is never issued
  task automatic load(input int p, input int w, input logic [15:0] d);
    wr(ADDR_PTR, ptr(p, w));
    wr(ADDR_DATA, {16'h0, d});
    cmd({3'h0, CMD_LOAD});
  endtask : load
  // bounded poll until store enable drops
  task automatic wait_done;
    for (int i = 0; i < 40; i++)
    begin
      cpu.xfer(1'b0, ADDR_CTRL, 32'h0, q, e);
      if (q[0] === 1'b0) break;
    end
    cpu.idle();
  endtask : wait_done
  task automatic t_load;
    chk("lock", 4'hF, lock_bits);
    buf_is(5'd3, 16'h0);
    load(5, 3, 16'hA5C3);
    buf_is(5'd3, 16'hA5C3);
    ctrl_is(8'h00);
  endtask : t_load
  // erase of updatable page, then read re-enable
  task automatic t_erase;
    wr(ADDR_CTRL, 32'h80);
    wr(ADDR_PTR, ptr(5, 0));
    op_cmd(8'h83);
    chk("erase", 1'b1, flash_erase);
    chk("page", 7'd5, flash_page);
    chk("stall", 1'b0, cpu_stall);
    chk("block", 1'b1, blk);
    chk("irq", 1'b0, ready_irq);
    @(posedge pclk);
    ctrl_is(8'hC3);
    wait_done();
    ctrl_is(8'hC0);
    chk("irq", 1'b1, ready_irq);
    buf_is(5'd3, 16'hA5C3);
    cmd(8'h91);
    ctrl_is(8'h80);
    buf_is(5'd3, 16'h0);
    load(5, 1, 16'h1111);
    wr(ADDR_CTRL, 32'h00);
  endtask : t_erase
  // write of nonupdatable page
  task automatic t_write;
    load(100, 7, 16'h1234);
    wr(ADDR_PTR, ptr(100, 0));
    op_cmd({3'h0, CMD_WRITE});
    chk("program", 1'b1, flash_program);
    chk("page", 7'd100, flash_page);
    chk("stall", 1'b1, cpu_stall);
    chk("block", 1'b1, blk);
    @(posedge pclk);
    wait_done();
    chk("stall", 1'b0, cpu_stall);
    buf_is(5'd7, 16'h0);
  endtask : t_write
  // lapsed window, undefined pattern, eeprom abort, lock set, unmapped
  task automatic t_misc;
    int n0;
    n0 = n_erase;
    wr(ADDR_CTRL, 32'h03);
    repeat (5) @(posedge pclk);
    wr(ADDR_STORE, 32'h0);
    ctrl_is(8'h00);
    cmd(8'h07);
    ctrl_is(8'h00);
    chk("erases", n0, n_erase);
    load(2, 2, 16'hBEEF);
    eeprom_write <= 1'b1;
    @(posedge pclk);
    eeprom_write <= 1'b0;
    buf_is(5'd2, 16'h0);
    wr(ADDR_DATA, 32'hEB);
    cmd({3'h0, CMD_LOCK});
    cpu.xfer(1'b0, ADDR_LOCK, 32'h0, q, e);
    cpu.idle();
    chk("lock", 32'hA, q);
    cpu.xfer(1'b0, 8'h20, 32'h0, q, e);
    cpu.idle();
    chk("slverr", 1'b1, e);
    chk("unmapped", 32'h0, q);
    chk("pready", 1'b1, pready);
  endtask : t_misc
  // reset in mid-run clears the buffer and sets the lock bits back to erased
  task automatic t_reset;
    load(4, 4, 16'h5A5A);
    buf_is(5'd4, 16'h5A5A);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    buf_is(5'd4, 16'h0);
    chk("lock", 4'hF, lock_bits);
  endtask : t_reset
  // report and stop
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  // watchdog well beyond the expected run
  initial
  begin
    #200us;
    num_errors++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_load();
    t_erase();
    t_write();
    t_misc();
    t_reset();
    give_verdict();
  end
endmodule : tb_flash_self_program_sequencer
`default_nettype wire
